// ==== rtl/edws_dev_end.sv ====
// Extended data window and stack check logic of the core data path.
// Assumes memory returns read data in the same cycle as the read strobe.
`timescale 1ns/1ps
`default_nettype none
module edws_dev_end
	import edws_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	// Core side
	edws_if.dev                    link,
	// Data memory side
	output logic [ADDR_W-1:0]      mem_addr_out,
	output logic                   mem_re_out,
	output logic                   mem_we_out,
	output logic [1:0]             mem_be_out,
	output logic [15:0]            mem_wdata_out,
	output logic                   mem_ext_out,
	input  wire logic [15:0]       mem_rdata_in,
	// Trap pulses
	output logic                   addr_trap_out,
	output logic                   stack_trap_out
);

	typedef enum logic {EDWS_DS_IDLE, EDWS_DS_BUSY} edws_dst_t;

	typedef struct packed {
		edws_dst_t         st;
		edws_kind_t        kind;
		edws_size_t        size;
		logic              rmw;
		logic              rep;
		logic              two;
		logic              phase;
		logic [1:0]        cnt;
		logic [EA_W-1:0]   ea;
		logic [WD_W-1:0]   wd;
		logic [9:0]        rpage;
		logic [8:0]        wpage;
		logic [15:0]       stack_limit_value;
		logic [15:0]       sp;
		logic [1:0]        rep_cnt;
		logic [ADDR_W-1:0] mem_addr;
		logic              mem_re;
		logic              mem_we;
		logic [1:0]        mem_be;
		logic [15:0]       mem_wd;
		logic              mem_ext;
		logic              done;
		logic [WD_W-1:0]   rdata;
		logic              atrap;
		logic              strap;
	} edws_dev_state_t;

	localparam edws_dev_state_t DEV_RST = '{
		st: EDWS_DS_IDLE, kind: EDWS_K_READ, size: EDWS_SZ_BYTE,
		rpage: RPAGE_RST, wpage: WPAGE_RST, stack_limit_value: STACK_LIMIT_VALUE_RST,
		sp: SP_RST, default: '0};

	edws_dev_state_t   cur_ff;
	edws_dev_state_t   nxt_st;

	// Phase inputs, taken from the link when idle
	logic              idle;
	edws_kind_t        ph_kind;
	logic              ph_rd;
	logic              ph_push;
	logic              ph_stack;
	logic              ph_rmw;
	logic              ph_rep;
	logic [1:0]        ph_rc;
	logic [EA_W-1:0]   ph_ea;
	logic [9:0]        ph_page;
	logic [WD_W-1:0]   start_wd;
	logic [ADDR_W-1:0] xl_addr;
	logic              xl_win;
	logic              xl_trap;
	logic              ovf;
	logic              unf;
	logic [1:0]        cost;

	always_comb begin
		idle     = (cur_ff.st == EDWS_DS_IDLE);
		ph_kind  = idle ? link.acc_kind : cur_ff.kind;
		ph_rmw   = idle ? link.acc_rmw : cur_ff.rmw;
		ph_rep   = idle ? link.acc_rep : cur_ff.rep;
		ph_rc    = (idle && !link.acc_rep) ? 2'h0 : cur_ff.rep_cnt;
		ph_rd    = (ph_kind == EDWS_K_READ) || (ph_kind == EDWS_K_POP);
		ph_push  = (ph_kind == EDWS_K_PUSH) || (ph_kind == EDWS_K_CALL) ||
			(ph_kind == EDWS_K_EXC);
		ph_stack = ph_push || (ph_kind == EDWS_K_POP);
		// Stack phases always follow the live pointer
		if (ph_stack) begin
			ph_ea = (ph_kind == EDWS_K_POP) ?
				cur_ff.sp - WORD_STEP : cur_ff.sp;
		end else if (idle) begin
			ph_ea = link.acc_ea;
		end else if (cur_ff.ea[WIN_BIT]) begin
			// Wrap inside the window, page stays put
			ph_ea = {1'b1, cur_ff.ea[14:0] + OFF_STEP};
		end else begin
			ph_ea = cur_ff.ea + WORD_STEP;
		end
		// Modify-writes share the read page
		ph_page = (ph_rd || ph_rmw) ?
			cur_ff.rpage : {1'b0, cur_ff.wpage};
		ovf = ph_push && (ph_ea > cur_ff.stack_limit_value);
		unf = ph_stack && (ph_ea < DATA_BASE);
		// Window reads pay overhead, except repeats past the first two; writes never do
		if (ph_rd && xl_win) begin
			if (ph_rep) begin
				cost = (ph_rc < REP_HEADS) ? COST_HEAD : COST_FAST;
			end else begin
				cost = COST_WIN;
			end
		end else begin
			cost = COST_FAST;
		end
		// Program counter pushes carry a top byte of their own
		case (link.acc_kind)
			EDWS_K_CALL: start_wd = {8'h00, link.acc_pc};
			EDWS_K_EXC:  start_wd = {link.acc_srl, link.acc_pc};
			default:     start_wd = link.acc_wdata;
		endcase
	end

	edws_xlate u_xlate (
		.ea_in    (ph_ea),
		.page_in  (ph_page),
		.addr_out (xl_addr),
		.win_out  (xl_win),
		.trap_out (xl_trap)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic start;
		start           = 1'b0;
		nxt_st          = cur_ff;
		nxt_st.done     = 1'b0;
		nxt_st.atrap    = 1'b0;
		nxt_st.strap    = 1'b0;
		nxt_st.mem_re   = 1'b0;
		nxt_st.mem_we   = 1'b0;
		// Page registers change only by explicit writes
		if (link.sfr_we) begin
			case (link.sfr_sel)
				EDWS_SFR_RPAGE: nxt_st.rpage = link.sfr_wdata[9:0];
				EDWS_SFR_WPAGE: nxt_st.wpage = link.sfr_wdata[8:0];
				EDWS_SFR_STACK_LIMIT_VALUE: nxt_st.stack_limit_value = {link.sfr_wdata[15:1],
					1'b0};
				EDWS_SFR_SP:    nxt_st.sp = {link.sfr_wdata[15:1], 1'b0};
				default:        nxt_st.sp = cur_ff.sp;
			endcase
		end
		case (cur_ff.st)
			EDWS_DS_IDLE: begin
				if (link.acc_valid) begin
					start        = 1'b1;
					nxt_st.kind  = link.acc_kind;
					nxt_st.size  = link.acc_size;
					nxt_st.rmw   = link.acc_rmw;
					nxt_st.rep   = link.acc_rep;
					nxt_st.wd    = start_wd;
					nxt_st.phase = 1'b0;
					nxt_st.two   = (link.acc_size == EDWS_SZ_DWORD) ||
						(link.acc_kind == EDWS_K_CALL) ||
						(link.acc_kind == EDWS_K_EXC);
					nxt_st.rep_cnt = ph_rc;
				end
			end
			EDWS_DS_BUSY: begin
				nxt_st.cnt    = cur_ff.cnt - 2'h1;
				nxt_st.mem_re = ph_rd && (cur_ff.cnt == 2'h2);
				if (cur_ff.cnt == 2'h1) begin
					// Strobe is visible now; data comes back with it
					if (ph_rd && cur_ff.phase) begin
						nxt_st.rdata[31:16] = mem_rdata_in;
					end else if (ph_rd) begin
						nxt_st.rdata[15:0] = mem_rdata_in;
					end
					if (cur_ff.two && !cur_ff.phase) begin
						start        = 1'b1;
						nxt_st.phase = 1'b1;
					end else begin
						nxt_st.st   = EDWS_DS_IDLE;
						nxt_st.done = 1'b1;
					end
				end
			end
			default: nxt_st.st = EDWS_DS_IDLE;
		endcase
		// Check and launch one word phase
		if (start) begin
			if (xl_trap || ovf || unf) begin
				nxt_st.atrap = xl_trap;
				nxt_st.strap = ovf || unf;
				nxt_st.done  = 1'b1;
				nxt_st.st    = EDWS_DS_IDLE;
			end else begin
				nxt_st.st       = EDWS_DS_BUSY;
				nxt_st.cnt      = cost;
				nxt_st.ea       = ph_ea;
				nxt_st.mem_addr = xl_addr;
				nxt_st.mem_ext  = xl_win && (xl_addr >= EXT_BASE);
				nxt_st.mem_re   = ph_rd && (cost == COST_FAST);
				nxt_st.mem_we   = !ph_rd;
				nxt_st.mem_wd   = nxt_st.phase ?
					nxt_st.wd[31:16] : nxt_st.wd[15:0];
				if (nxt_st.size == EDWS_SZ_BYTE && !ph_stack) begin
					nxt_st.mem_be = ph_ea[0] ? 2'b10 : 2'b01;
				end else begin
					nxt_st.mem_be = 2'b11;
				end
				if (ph_push) begin
					nxt_st.sp = cur_ff.sp + WORD_STEP;
				end else if (ph_stack) begin
					nxt_st.sp = cur_ff.sp - WORD_STEP;
				end
				if (ph_rd && xl_win && ph_rep && ph_rc < REP_HEADS) begin
					nxt_st.rep_cnt = ph_rc + 2'h1;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur_ff <= DEV_RST;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign mem_addr_out   = cur_ff.mem_addr;
	assign mem_re_out     = cur_ff.mem_re;
	assign mem_we_out     = cur_ff.mem_we;
	assign mem_be_out     = cur_ff.mem_be;
	assign mem_wdata_out  = cur_ff.mem_wd;
	assign mem_ext_out    = cur_ff.mem_ext;
	assign addr_trap_out  = cur_ff.atrap;
	assign stack_trap_out = cur_ff.strap;
	assign link.acc_done  = cur_ff.done;
	assign link.acc_rdata = cur_ff.rdata;
	assign link.acc_atrap = cur_ff.atrap;
	assign link.acc_strap = cur_ff.strap;
	assign link.acc_busy  = (cur_ff.st == EDWS_DS_BUSY);
	assign link.acc_sp    = cur_ff.sp;

endmodule : edws_dev_end
`default_nettype wire

// ==== rtl/edws_pkg.sv ====
// Constants and types shared by both ends of the extended data window.
// Assumes a 16-bit core issuing one access at a time on one clock.
package edws_pkg;

	// Address and data widths
	localparam int EA_W      = 16;
	localparam int ADDR_W    = 24;
	localparam int WIN_BIT   = 15;
	localparam int PSV_BIT   = 9;
	localparam int WD_W      = 32;

	// Fixed bounds and steps
	localparam logic [15:0] DATA_BASE = 16'h0800;
	localparam logic [23:0] EXT_BASE  = 24'h01_8800;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [14:0] OFF_STEP  = 15'h0002;

	// Cycle costs of one word phase
	localparam logic [1:0] COST_FAST = 2'h1;
	localparam logic [1:0] COST_WIN  = 2'h2;
	localparam logic [1:0] COST_HEAD = 2'h3;
	localparam logic [1:0] REP_HEADS = 2'h2;

	// Reset values
	localparam logic [9:0]  RPAGE_RST = 10'h000;
	localparam logic [8:0]  WPAGE_RST = 9'h000;
	localparam logic [15:0] STACK_LIMIT_VALUE_RST = 16'h0000;
	localparam logic [15:0] SP_RST    = 16'h0800;

	// Controller register offsets
	localparam logic [3:0] HR_CMD    = 4'h0;
	localparam logic [3:0] HR_EA     = 4'h1;
	localparam logic [3:0] HR_WDATA  = 4'h2;
	localparam logic [3:0] HR_PC     = 4'h3;
	localparam logic [3:0] HR_SFR    = 4'h4;
	localparam logic [3:0] HR_STATUS = 4'h5;
	localparam logic [3:0] HR_RDATA  = 4'h6;

	// Field positions
	localparam int CMD_SIZE_LSB = 4;
	localparam int CMD_RMW_BIT  = 8;
	localparam int CMD_REP_BIT  = 9;
	localparam int CMD_SRL_LSB  = 16;
	localparam int SFR_SEL_LSB  = 16;

	typedef enum logic [2:0] {
		EDWS_K_READ, EDWS_K_WRITE, EDWS_K_PUSH,
		EDWS_K_POP, EDWS_K_CALL, EDWS_K_EXC
	} edws_kind_t;

	typedef enum logic [1:0] {
		EDWS_SZ_BYTE, EDWS_SZ_WORD, EDWS_SZ_DWORD
	} edws_size_t;

	typedef enum logic [1:0] {
		EDWS_SFR_RPAGE, EDWS_SFR_WPAGE, EDWS_SFR_STACK_LIMIT_VALUE, EDWS_SFR_SP
	} edws_sfr_t;

endpackage : edws_pkg

// ==== rtl/edws_if.sv ====
// Link between the core-side controller and the window logic.
// Assumes both ends share one clock; no clocking here.
`timescale 1ns/1ps
`default_nettype none
interface edws_if;
	import edws_pkg::*;

	logic              sfr_we;
	edws_sfr_t         sfr_sel;
	logic [15:0]       sfr_wdata;
	logic              acc_valid;
	edws_kind_t        acc_kind;
	edws_size_t        acc_size;
	logic              acc_rmw;
	logic              acc_rep;
	logic [EA_W-1:0]   acc_ea;
	logic [WD_W-1:0]   acc_wdata;
	logic [23:0]       acc_pc;
	logic [7:0]        acc_srl;
	logic              acc_done;
	logic [WD_W-1:0]   acc_rdata;
	logic              acc_atrap;
	logic              acc_strap;
	logic              acc_busy;
	logic [15:0]       acc_sp;

	modport dev (
		input  sfr_we, sfr_sel, sfr_wdata, acc_valid, acc_kind, acc_size,
		input  acc_rmw, acc_rep, acc_ea, acc_wdata, acc_pc, acc_srl,
		output acc_done, acc_rdata, acc_atrap, acc_strap, acc_busy, acc_sp
	);

	modport core (
		output sfr_we, sfr_sel, sfr_wdata, acc_valid, acc_kind, acc_size,
		output acc_rmw, acc_rep, acc_ea, acc_wdata, acc_pc, acc_srl,
		input  acc_done, acc_rdata, acc_atrap, acc_strap, acc_busy, acc_sp
	);

endinterface : edws_if
`default_nettype wire

// ==== rtl/edws_xlate.sv ====
// Effective address to 24-bit data address translation, combinational.
// Assumes the caller has already chosen the read or write page.
`timescale 1ns/1ps
`default_nettype none
module edws_xlate
	import edws_pkg::*;
(
	// Address and page in
	input  wire logic [EA_W-1:0]   ea_in,
	input  wire logic [9:0]        page_in,
	// Translation out
	output logic [ADDR_W-1:0]      addr_out,
	output logic                   win_out,
	output logic                   trap_out
);

	// Window when the top address bit is set
	always_comb begin
		win_out = ea_in[WIN_BIT];
		if (ea_in[WIN_BIT]) begin
			addr_out = {page_in[8:0], ea_in[14:0]};
		end else begin
			addr_out = {8'h00, ea_in};
		end
		// Page 0 is base memory; program-space pages are not served here
		trap_out = ea_in[WIN_BIT] &&
			((page_in[8:0] == 9'h000) || page_in[PSV_BIT]);
	end

endmodule : edws_xlate
`default_nettype wire

// ==== rtl/edws_core_end.sv ====
// Core-side controller that drives the window logic from a register port.
// Assumes software writes offsets with bit 15 set for window accesses.
`timescale 1ns/1ps
`default_nettype none
module edws_core_end
	import edws_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	// Window logic side
	edws_if.core                   link,
	// Software register port
	input  wire logic [3:0]        reg_addr_in,
	input  wire logic [31:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic [31:0]            reg_rdata_out
);

	typedef struct packed {
		edws_kind_t      kind;
		edws_size_t      size;
		logic            rmw;
		logic            rep;
		logic [7:0]      status_low_byte;
		logic [EA_W-1:0] ea;
		logic [WD_W-1:0] wd;
		logic [23:0]     pc;
		logic            pend;
		logic            busy;
		logic            guard;
		logic            refused;
		logic            atrap;
		logic            strap;
		logic [WD_W-1:0] rdata;
		logic [31:0]     reg_rdata;
		logic            valid;
		logic            sfr_we;
		edws_sfr_t       sfr_sel;
		logic [15:0]     sfr_wd;
	} edws_core_state_t;

	localparam edws_core_state_t CORE_RST = '{kind: EDWS_K_READ,
		size: EDWS_SZ_BYTE, sfr_sel: EDWS_SFR_RPAGE, default: '0};

	edws_core_state_t cur_ff;
	edws_core_state_t nxt_st;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		nxt_st        = cur_ff;
		nxt_st.valid  = 1'b0;
		nxt_st.sfr_we = 1'b0;
		nxt_st.guard  = 1'b0;
		nxt_st.reg_rdata = 32'h0000_0000;
		// Register writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				HR_EA:    nxt_st.ea = reg_wdata_in[15:0];
				HR_WDATA: nxt_st.wd = reg_wdata_in;
				HR_PC:    nxt_st.pc = reg_wdata_in[23:0];
				HR_SFR: begin
					// Pages reach the window only through here
					nxt_st.sfr_we  = 1'b1;
					nxt_st.sfr_sel = edws_sfr_t'(
						reg_wdata_in[SFR_SEL_LSB +: 2]);
					nxt_st.sfr_wd  = reg_wdata_in[15:0];
					nxt_st.guard   = (reg_wdata_in[SFR_SEL_LSB +: 2] ==
						EDWS_SFR_STACK_LIMIT_VALUE);
				end
				HR_CMD: begin
					if (cur_ff.pend || cur_ff.busy ||
						(reg_wdata_in[CMD_RMW_BIT] &&
						reg_wdata_in[CMD_REP_BIT] &&
						cur_ff.ea[WIN_BIT])) begin
						nxt_st.refused = 1'b1;
					end else begin
						nxt_st.kind    = edws_kind_t'(reg_wdata_in[2:0]);
						nxt_st.size    = edws_size_t'(
							reg_wdata_in[CMD_SIZE_LSB +: 2]);
						nxt_st.rmw     = reg_wdata_in[CMD_RMW_BIT];
						nxt_st.rep     = reg_wdata_in[CMD_REP_BIT];
						nxt_st.status_low_byte     = reg_wdata_in[CMD_SRL_LSB +: 8];
						nxt_st.pend    = 1'b1;
						nxt_st.refused = 1'b0;
						nxt_st.atrap   = 1'b0;
						nxt_st.strap   = 1'b0;
					end
				end
				default: nxt_st.pend = cur_ff.pend;
			endcase
		end
		// Hold a stack read off the cycle after a limit write
		if (cur_ff.pend && !cur_ff.busy &&
			!(cur_ff.guard && cur_ff.kind == EDWS_K_POP)) begin
			nxt_st.valid = 1'b1;
			nxt_st.pend  = 1'b0;
			nxt_st.busy  = 1'b1;
		end
		// Completion sets status
		if (link.acc_done) begin
			nxt_st.busy  = 1'b0;
			nxt_st.rdata = link.acc_rdata;
			nxt_st.atrap = link.acc_atrap;
			nxt_st.strap = link.acc_strap;
		end
		// Register reads answer one cycle later
		if (reg_rd_in) begin
			case (reg_addr_in)
				HR_STATUS: nxt_st.reg_rdata = {link.acc_sp, 12'h000,
					cur_ff.refused, cur_ff.strap, cur_ff.atrap,
					cur_ff.busy || cur_ff.pend};
				HR_RDATA:  nxt_st.reg_rdata = cur_ff.rdata;
				HR_EA:     nxt_st.reg_rdata = {16'h0000, cur_ff.ea};
				HR_WDATA:  nxt_st.reg_rdata = cur_ff.wd;
				HR_PC:     nxt_st.reg_rdata = {8'h00, cur_ff.pc};
				default:   nxt_st.reg_rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur_ff <= CORE_RST;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign reg_rdata_out  = cur_ff.reg_rdata;
	assign link.acc_valid = cur_ff.valid;
	assign link.acc_kind  = cur_ff.kind;
	assign link.acc_size  = cur_ff.size;
	assign link.acc_rmw   = cur_ff.rmw;
	assign link.acc_rep   = cur_ff.rep;
	assign link.acc_ea    = cur_ff.ea;
	assign link.acc_wdata = cur_ff.wd;
	assign link.acc_pc    = cur_ff.pc;
	assign link.acc_srl   = cur_ff.status_low_byte;
	assign link.sfr_we    = cur_ff.sfr_we;
	assign link.sfr_sel   = cur_ff.sfr_sel;
	assign link.sfr_wdata = cur_ff.sfr_wd;

endmodule : edws_core_end
`default_nettype wire

// ==== bench/edws_sva.sv ====
// Checker for the link between core end and window logic.
// Assumes the link signals as plain inputs and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module edws_sva
	import edws_pkg::*;
(
	// Clock and reset
	input  wire logic            clk_in,
	input  wire logic            rst_n_in,
	// Register updates
	input  wire logic            sfr_we,
	input  var  edws_sfr_t       sfr_sel,
	input  wire logic [15:0]     sfr_wdata,
	// Requests
	input  wire logic            acc_valid,
	input  var  edws_kind_t      acc_kind,
	input  var  edws_size_t      acc_size,
	input  wire logic            acc_rmw,
	input  wire logic            acc_rep,
	input  wire logic [EA_W-1:0] acc_ea,
	// Answers
	input  wire logic            acc_done,
	input  wire logic            acc_atrap,
	input  wire logic            acc_strap,
	input  wire logic            acc_busy,
	input  wire logic [15:0]     acc_sp
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////////////////////////////////////////////
	// Shadow copies of pages and limit; they follow the link writes
	logic [9:0]  rpage_ff;
	logic [8:0]  wpage_ff;
	logic [15:0] lim_ff;
	logic        take;
	logic        one;
	logic        push_ok;
	assign take = acc_valid && !acc_busy;
	assign one = acc_size != EDWS_SZ_DWORD;
	assign push_ok = take && acc_kind == EDWS_K_PUSH && one
		&& acc_sp <= lim_ff && acc_sp >= DATA_BASE;

	// Bit 0 of the limit is dropped as the device does
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rpage_ff <= RPAGE_RST;
			wpage_ff <= WPAGE_RST;
			lim_ff <= STACK_LIMIT_VALUE_RST;
		end else if (sfr_we) begin
			case (sfr_sel)
			EDWS_SFR_RPAGE: rpage_ff <= sfr_wdata[9:0];
			EDWS_SFR_WPAGE: wpage_ff <= sfr_wdata[8:0];
			EDWS_SFR_STACK_LIMIT_VALUE: lim_ff <= {sfr_wdata[15:1], 1'b0};
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timing and trap relations
	win_write_a: assert property (take && acc_kind == EDWS_K_WRITE
		&& acc_ea[WIN_BIT] && wpage_ff != 0 && !acc_rmw && one
		|-> ##2 acc_done) else $error("window write not single cycle");
	low_read_a: assert property (take && acc_kind == EDWS_K_READ
		&& !acc_ea[WIN_BIT] && one |-> ##2 (acc_done && !acc_atrap))
		else $error("low read timing or trap wrong");
	win_read_a: assert property (take && acc_kind == EDWS_K_READ
		&& acc_ea[WIN_BIT] && !acc_rep && one && rpage_ff[8:0] != 0
		&& !rpage_ff[9] |-> ##1 !acc_done [*2] ##1 acc_done)
		else $error("window read cost not two cycles");
	page_zero_a: assert property (take && acc_kind == EDWS_K_READ
		&& acc_ea[WIN_BIT] && rpage_ff[8:0] == 0 |=> acc_done && acc_atrap)
		else $error("page zero read did not trap");
	trap_done_a: assert property ((acc_atrap || acc_strap)
		|-> acc_done) else $error("trap pulse without done");
	push_over_a: assert property (take && acc_kind == EDWS_K_PUSH
		&& acc_sp > lim_ff |=> acc_strap)
		else $error("push above limit did not trap");
	push_equal_a: assert property (push_ok && acc_sp == lim_ff
		|=> !acc_strap ##1 (acc_done && !acc_strap))
		else $error("push at limit trapped");
	push_step_a: assert property (push_ok
		|-> ##3 acc_sp == $past(acc_sp, 3) + WORD_STEP)
		else $error("push did not advance pointer by one word");
	pop_under_a: assert property (take && acc_kind == EDWS_K_POP
		&& acc_sp < DATA_BASE + WORD_STEP |=> acc_strap)
		else $error("pop below data base did not trap");

	// Main scenarios
	cov_win_read: cover property (take && acc_kind == EDWS_K_READ
		&& acc_ea[WIN_BIT] && !acc_rep ##3 acc_done);
	cov_page_zero: cover property (acc_atrap);
	cov_stack_trap: cover property (acc_strap);
endmodule : edws_sva
`default_nettype wire

// ==== bench/tb_extended_data_window_and_stack_check.sv ====
// Testbench: core end and window logic joined by the link interface.
// Assumes memory answers combinationally with the inverted low address.
`timescale 1ns/1ps
`default_nettype none
module tb_extended_data_window_and_stack_check
	import edws_pkg::*;
;
	logic        clk_in, rst_n_in, reg_wr, reg_rd, mem_re, mem_we, mem_ext;
	logic        last_ext, atrap_pin, strap_pin;
	logic [1:0]  mem_be, last_be, last_trap;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, st, d;
	logic [23:0] mem_addr, last_addr;
	logic [15:0] mem_wdata, last_wd;
	logic [7:0]  status_low_byte;
	int          errors = 0, checks_done = 0, cycles = 0, n_strobe = 0, n0;

	edws_if i_edws_if ();
	edws_dev_end i_edws_dev_end (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link(i_edws_if.dev), .mem_addr_out(mem_addr), .mem_re_out(mem_re),
		.mem_we_out(mem_we), .mem_be_out(mem_be), .mem_wdata_out(mem_wdata),
		.mem_ext_out(mem_ext), .mem_rdata_in(~mem_addr[15:0]),
		.addr_trap_out(atrap_pin), .stack_trap_out(strap_pin));
	edws_core_end i_edws_core_end (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link(i_edws_if.core), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata));
	edws_sva i_edws_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.sfr_we(i_edws_if.sfr_we), .sfr_sel(i_edws_if.sfr_sel),
		.sfr_wdata(i_edws_if.sfr_wdata), .acc_valid(i_edws_if.acc_valid),
		.acc_kind(i_edws_if.acc_kind), .acc_size(i_edws_if.acc_size),
		.acc_rmw(i_edws_if.acc_rmw), .acc_rep(i_edws_if.acc_rep),
		.acc_ea(i_edws_if.acc_ea), .acc_done(i_edws_if.acc_done),
		.acc_atrap(i_edws_if.acc_atrap), .acc_strap(i_edws_if.acc_strap),
		.acc_busy(i_edws_if.acc_busy), .acc_sp(i_edws_if.acc_sp));

	////////////////////////////////////////////////////////////////////////
	// Clock, memory monitor and hang guard
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (mem_we || mem_re) begin
			last_addr <= mem_addr;
			last_wd <= mem_wdata;
			last_ext <= mem_ext;
			last_be <= mem_be;
			n_strobe <= n_strobe + 1;
		end
		// Trap pins pulse once; keep which one fired last
		if (atrap_pin || strap_pin) begin
			last_trap <= {atrap_pin, strap_pin};
		end
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus tasks; each leaves one idle edge so strobes never collide
	task automatic chk(input logic [31:0] got, exp, input string what);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_in);
		reg_wr <= 1'b0;
		@(posedge clk_in);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		@(negedge clk_in);
		v = reg_rdata;
		@(posedge clk_in);
	endtask : rd
	task automatic sfr(input edws_sfr_t s, input logic [15:0] v);
		wr(HR_SFR, (32'(s) << SFR_SEL_LSB) | 32'(v));
	endtask : sfr
	// Flags: bit 0 read-modify-write, bit 1 repeat
	task automatic op(input edws_kind_t k, input edws_size_t s,
		input logic [15:0] ea, input logic [31:0] wd, input logic [1:0] f);
		int n;
		wr(HR_EA, 32'(ea));
		wr(HR_WDATA, wd);
		wr(HR_CMD, 32'(k) | (32'(s) << CMD_SIZE_LSB) | (32'(f[0]) << CMD_RMW_BIT)
			| (32'(f[1]) << CMD_REP_BIT) | (32'(status_low_byte) << CMD_SRL_LSB));
		n = 0;
		rd(HR_STATUS, st);
		while (st[0] !== 1'b0 && n < 50) begin
			rd(HR_STATUS, st);
			n++;
		end
		chk(32'(n < 50), 32'h0000_0001, "completion");
	endtask : op

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_window;
		sfr(EDWS_SFR_WPAGE, 16'h0002);
		sfr(EDWS_SFR_RPAGE, 16'h0002);
		op(EDWS_K_WRITE, EDWS_SZ_WORD, 16'h8800, 32'h0000_1234, 2'b00);
		chk({8'h00, last_addr}, 32'h0001_0800, "write addr");
		chk({16'h0000, last_wd}, 32'h0000_1234, "write data");
		op(EDWS_K_READ, EDWS_SZ_WORD, 16'h8800, 32'h0000_0000, 2'b00);
		rd(HR_RDATA, d);
		chk(d & 32'h0000_FFFF, 32'h0000_F7FF, "read data");
		op(EDWS_K_READ, EDWS_SZ_WORD, 16'h8802, 32'h0000_0000, 2'b10);
		rd(HR_RDATA, d);
		chk(d & 32'h0000_FFFF, 32'h0000_F7FD, "repeat read");
		sfr(EDWS_SFR_WPAGE, 16'h0003);
		n0 = n_strobe;
		op(EDWS_K_WRITE, EDWS_SZ_DWORD, 16'hFFFE, 32'h4455_1122, 2'b00);
		chk(32'(n_strobe - n0), 32'h0000_0002, "dword phases");
		chk({8'h00, last_addr}, 32'h0001_8000, "wrap addr");
		chk({16'h0000, last_wd}, 32'h0000_4455, "second word");
		sfr(EDWS_SFR_WPAGE, 16'h0004);
		op(EDWS_K_WRITE, EDWS_SZ_BYTE, 16'h8801, 32'h0000_00A5, 2'b00);
		chk(32'({last_ext, last_addr}), 32'h0102_0801, "ext page");
		chk(32'(last_be), 32'h0000_0002, "byte lane");
	endtask : t_window
	task automatic t_low_trap;
		sfr(EDWS_SFR_WPAGE, 16'h0000);
		sfr(EDWS_SFR_RPAGE, 16'h0000);
		op(EDWS_K_WRITE, EDWS_SZ_WORD, 16'h1234, 32'h0000_BEEF, 2'b00);
		chk({8'h00, last_addr}, 32'h0000_1234, "low addr");
		chk(st & 32'h0000_000E, 32'h0000_0000, "low no trap");
		op(EDWS_K_READ, EDWS_SZ_WORD, 16'h1234, 32'h0000_0000, 2'b00);
		rd(HR_RDATA, d);
		chk(d & 32'h0000_FFFF, 32'h0000_EDCB, "low read");
		n0 = n_strobe;
		op(EDWS_K_READ, EDWS_SZ_WORD, 16'h8000, 32'h0000_0000, 2'b00);
		chk(st & 32'h0000_000F, 32'h0000_0002, "page zero");
		chk(32'(last_trap), 32'h0000_0002, "trap pin");
		sfr(EDWS_SFR_RPAGE, 16'h0201);
		op(EDWS_K_READ, EDWS_SZ_WORD, 16'h8000, 32'h0000_0000, 2'b00);
		chk(st & 32'h0000_0002, 32'h0000_0002, "program page");
		chk(32'(n_strobe - n0), 32'h0000_0000, "no access");
	endtask : t_low_trap
	task automatic t_rmw;
		sfr(EDWS_SFR_RPAGE, 16'h0005);
		sfr(EDWS_SFR_WPAGE, 16'h0007);
		op(EDWS_K_READ, EDWS_SZ_WORD, 16'h8010, 32'h0000_0000, 2'b01);
		op(EDWS_K_WRITE, EDWS_SZ_WORD, 16'h8010, 32'h0000_0077, 2'b01);
		chk({8'h00, last_addr}, 32'h0002_8010, "rmw page");
		op(EDWS_K_READ, EDWS_SZ_WORD, 16'h8010, 32'h0000_0000, 2'b11);
		chk(st & 32'h0000_0009, 32'h0000_0008, "rmw repeat");
	endtask : t_rmw
	task automatic t_stack;
		sfr(EDWS_SFR_SP, 16'h1000);
		sfr(EDWS_SFR_STACK_LIMIT_VALUE, 16'h1003);
		op(EDWS_K_PUSH, EDWS_SZ_WORD, 16'h0000, 32'h0000_0001, 2'b00);
		chk({8'h00, last_addr}, 32'h0000_1000, "push addr");
		chk(st & 32'hFFFF_0006, 32'h1002_0000, "push step");
		op(EDWS_K_PUSH, EDWS_SZ_WORD, 16'h0000, 32'h0000_0002, 2'b00);
		chk(st & 32'hFFFF_0006, 32'h1004_0000, "push at limit");
		op(EDWS_K_PUSH, EDWS_SZ_WORD, 16'h0000, 32'h0000_0003, 2'b00);
		chk(st & 32'hFFFF_0006, 32'h1004_0004, "push over");
		chk(32'(last_trap), 32'h0000_0001, "stack pin");
		op(EDWS_K_POP, EDWS_SZ_WORD, 16'h0000, 32'h0000_0000, 2'b00);
		chk({8'h00, last_addr}, 32'h0000_1002, "pop addr");
		sfr(EDWS_SFR_SP, 16'h1100);
		sfr(EDWS_SFR_STACK_LIMIT_VALUE, 16'hFFFE);
		wr(HR_PC, 32'h0012_3456);
		op(EDWS_K_CALL, EDWS_SZ_WORD, 16'h0000, 32'h0000_0000, 2'b00);
		chk({16'h0000, last_wd}, 32'h0000_0012, "call top");
		status_low_byte = 8'hA5;
		op(EDWS_K_EXC, EDWS_SZ_WORD, 16'h0000, 32'h0000_0000, 2'b00);
		chk({16'h0000, last_wd}, 32'h0000_A512, "exc top");
		chk(st & 32'hFFFF_0006, 32'h1108_0000, "frame size");
		sfr(EDWS_SFR_SP, 16'h0800);
		op(EDWS_K_POP, EDWS_SZ_WORD, 16'h0000, 32'h0000_0000, 2'b00);
		chk(st & 32'h0000_0004, 32'h0000_0004, "underflow");
	endtask : t_stack

	////////////////////////////////////////////////////////////////////////
	// Verdict and main sequence
	task automatic complete_run;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	initial begin
		rst_n_in = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		status_low_byte = 8'h00;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		rd(HR_STATUS, d);
		chk(d, 32'h0800_0000, "reset status");
		wr(4'hF, 32'hFFFF_FFFF);
		rd(4'hF, d);
		chk(d, 32'h0000_0000, "unmapped");
		t_window();
		t_low_trap();
		t_rmw();
		t_stack();
		complete_run();
	end
endmodule : tb_extended_data_window_and_stack_check
`default_nettype wire
